//--- inc/tpo_params.svh
// Constants for the timed pattern output block
`ifndef TPO_PARAMS_SVH
`define TPO_PARAMS_SVH
`define TPO_PINS 16
`define TPO_GROUPS 4
`define TPO_GW 4
`define TPO_FIFO_DEPTH 32
// Device register indices
`define TPO_IDX_NPAT_LO 4'h0
`define TPO_IDX_NPAT_HI 4'h1
`define TPO_IDX_NEN_LO 4'h2
`define TPO_IDX_NEN_HI 4'h3
`define TPO_IDX_DIR_A 4'h4
`define TPO_IDX_DIR_B 4'h5
`define TPO_IDX_PORT_A 4'h6
`define TPO_IDX_PORT_B 4'h7
`define TPO_IDX_TSEL 4'h8
`define TPO_IDX_NOV 4'h9
`define TPO_TSEL_RST 8'hff
`define TPO_NOV_RST 4'h0
`define TPO_NOV_RSVD 4'hf
// Controller register offsets
`define TPO_A_CTRL 8'h00
`define TPO_A_STATUS 8'h04
`define TPO_A_FIFO 8'h08
`define TPO_A_DEVCMD 8'h0c
`define TPO_A_DEVRD 8'h10
`define TPO_A_TAKEOVER 8'h14
`define TPO_CH_REGION 3'h1
`define TPO_CMD_RD_BIT 20
`define TPO_CH_MODE_BIT 16
`define TPO_RESP_OKAY 2'h0
`define TPO_RESP_SLVERR 2'h2
`endif

//--- inc/tpo_pkg.sv
// Types shared by both ends of the timed pattern output block
package tpo_pkg;
    typedef logic [15:0] tpo_pat_t;
    typedef enum logic [1:0] {
        FEED_IDLE = 2'h0,
        FEED_WAIT = 2'h1,
        FEED_LO = 2'h3,
        FEED_HI = 2'h2
    } tpo_feed_e;
endpackage

//--- inc/tpo_if.sv
// Link between the pattern output device and its timer and controller
`timescale 1ns/100ps
interface tpo_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic reg_wr;
    logic reg_rd;
    logic [3:0] reg_idx;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [3:0] match_a;
    logic [3:0] match_b;
    logic [3:0] capture_a;
    logic [3:0] capture_mode;
    logic [15:0] takeover;

    modport dev (
        input aclk, aresetn, reg_wr, reg_rd, reg_idx, reg_wdata,
        input match_a, match_b, capture_a, capture_mode, takeover,
        output reg_rdata
    );
    modport ctl (
        input aclk, aresetn, reg_rdata,
        output reg_wr, reg_rd, reg_idx, reg_wdata,
        output match_a, match_b, capture_a, capture_mode, takeover
    );
endinterface

//--- src/tpo_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
module tpo_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign count = cnt_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

//--- src/tpo_device.sv
// Timed pattern output device end: registers, trigger decode, pin drive
`timescale 1ns/100ps
`include "tpo_params.svh"
module tpo_device
    import tpo_pkg::*;
(
    // Link to timer and controller
    tpo_if.dev link,
    // Pins
    input wire logic [15:0] pin_in,
    output logic [15:0] pattern_pin_out,
    output logic [15:0] pattern_pin_oe,
    output logic [15:0] pattern_active
);
    logic aclk;
    logic aresetn;
    tpo_pat_t npat_r;
    tpo_pat_t nen_r;
    tpo_pat_t dir_r;
    tpo_pat_t port_r;
    tpo_pat_t port_nxt;
    tpo_pat_t sw_mask;
    tpo_pat_t sw_val;
    tpo_pat_t xfer_mask;
    tpo_pat_t oe_r;
    tpo_pat_t active_r;
    logic [7:0] tsel_r;
    logic [3:0] nov_r;
    logic [7:0] rdata_r;
    logic [7:0] rd_mux;

    assign aclk = link.aclk;
    assign aresetn = link.aresetn;

    // Register writes other than the port value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            npat_r <= '0;
            nen_r <= '0;
            dir_r <= '0;
            tsel_r <= `TPO_TSEL_RST;
            nov_r <= `TPO_NOV_RST;
        end else if (link.reg_wr) begin
            case (link.reg_idx)
                `TPO_IDX_NPAT_LO: npat_r[7:0] <= link.reg_wdata;
                `TPO_IDX_NPAT_HI: npat_r[15:8] <= link.reg_wdata;
                `TPO_IDX_NEN_LO: nen_r[7:0] <= link.reg_wdata;
                `TPO_IDX_NEN_HI: nen_r[15:8] <= link.reg_wdata;
                `TPO_IDX_DIR_A: dir_r[7:0] <= link.reg_wdata;
                `TPO_IDX_DIR_B: dir_r[15:8] <= link.reg_wdata;
                `TPO_IDX_TSEL: tsel_r <= link.reg_wdata;
                `TPO_IDX_NOV: nov_r <= link.reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // Per-group trigger decode and transfer mask
    genvar g;
    generate
        for (g = 0; g < `TPO_GROUPS; g++) begin : grp
            logic [1:0] ch;
            logic ev_a;
            logic ev_b;
            logic [`TPO_GW-1:0] npat_g;
            logic [`TPO_GW-1:0] pick;
            assign ch = tsel_r[2*g+1 -: 2];
            // Capture replaces match A when the channel captures
            assign ev_a = link.capture_mode[ch] ? link.capture_a[ch]
                                                : link.match_a[ch];
            // Match B only counts in non-overlap mode
            assign ev_b = nov_r[g] && link.match_b[ch] && !link.capture_mode[ch];
            assign npat_g = npat_r[`TPO_GW*g +: `TPO_GW];
            always_comb begin
                pick = '0;
                if (ev_a) begin
                    pick = '1;
                end else if (ev_b) begin
                    pick = ~npat_g;
                end
            end
            // Enabled bits only, pin usage ignored
            assign xfer_mask[`TPO_GW*g +: `TPO_GW] =
                pick & nen_r[`TPO_GW*g +: `TPO_GW];
        end
    endgenerate

    // Software write into the port value
    always_comb begin
        sw_mask = '0;
        sw_val = '0;
        if (link.reg_wr && link.reg_idx == `TPO_IDX_PORT_A) begin
            sw_mask[7:0] = '1;
            sw_val[7:0] = link.reg_wdata;
        end
        if (link.reg_wr && link.reg_idx == `TPO_IDX_PORT_B) begin
            sw_mask[15:8] = '1;
            sw_val[15:8] = link.reg_wdata;
        end
        sw_mask = sw_mask & ~(nen_r & ~dir_r);
    end

    // Trigger beats a same-cycle software write
    always_comb begin
        port_nxt = (port_r & ~sw_mask) | (sw_val & sw_mask);
        port_nxt = (port_nxt & ~xfer_mask) | (npat_r & xfer_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_r <= '0;
        end else begin
            port_r <= port_nxt;
        end
    end

    // Pin drive; enabled pin first shows port value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_r <= '0;
            active_r <= '0;
        end else begin
            oe_r <= dir_r & ~link.takeover;
            active_r <= dir_r & nen_r & ~link.takeover;
        end
    end

    assign pattern_pin_out = port_r;
    assign pattern_pin_oe = oe_r;
    assign pattern_active = active_r;

    // Readback, one cycle after read strobe
    always_comb begin
        case (link.reg_idx)
            `TPO_IDX_NPAT_LO: rd_mux = npat_r[7:0];
            `TPO_IDX_NPAT_HI: rd_mux = npat_r[15:8];
            `TPO_IDX_NEN_LO: rd_mux = nen_r[7:0];
            `TPO_IDX_NEN_HI: rd_mux = nen_r[15:8];
            `TPO_IDX_DIR_A: rd_mux = dir_r[7:0];
            `TPO_IDX_DIR_B: rd_mux = dir_r[15:8];
            `TPO_IDX_PORT_A: rd_mux = (port_r[7:0] & dir_r[7:0])
                                    | (pin_in[7:0] & ~dir_r[7:0]);
            `TPO_IDX_PORT_B: rd_mux = (port_r[15:8] & dir_r[15:8])
                                    | (pin_in[15:8] & ~dir_r[15:8]);
            `TPO_IDX_TSEL: rd_mux = tsel_r;
            `TPO_IDX_NOV: rd_mux = {`TPO_NOV_RSVD, nov_r};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= '0;
        end else if (link.reg_rd) begin
            rdata_r <= rd_mux;
        end
    end

    assign link.reg_rdata = rdata_r;
endmodule

//--- src/tpo_ctrl.sv
// Controller end: timer channels, pattern feeder and AXI4-Lite registers
`timescale 1ns/100ps
`include "tpo_params.svh"
module tpo_ctrl
    import tpo_pkg::*;
(
    // Link to the device
    tpo_if.ctl link,
    // Capture inputs
    input wire logic [3:0] capture_in,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic aclk;
    logic aresetn;
    logic [3:0] run_r;
    logic feed_en_r;
    logic [1:0] feed_ch_r;
    logic [15:0] take_r;
    logic [15:0] cmp_a_r [4];
    logic [15:0] cmp_b_r [4];
    logic [3:0] cap_mode_r;
    logic [3:0] clr_b_r;
    logic [3:0] ma_r;
    logic [3:0] mb_r;
    logic [3:0] ca_r;
    logic [3:0] cap_prev_r;
    tpo_feed_e feed_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic do_wr;
    logic wr_ok;
    logic dev_pend_r;
    logic dev_is_rd_r;
    logic [3:0] dev_idx_r;
    logic [7:0] dev_data_r;
    logic [7:0] dev_rd_r;
    logic dev_rd_wait_r;
    logic rwr_r;
    logic rrd_r;
    logic [3:0] ridx_r;
    logic [7:0] rwdata_r;
    logic feed_busy;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [15:0] fifo_out;
    logic [5:0] fifo_cnt;
    logic [31:0] rd_mux;
    logic rd_ok;
    logic trig_a;

    assign aclk = link.aclk;
    assign aresetn = link.aresetn;
    assign feed_busy = (feed_r == FEED_LO) || (feed_r == FEED_HI);
    assign trig_a = cap_mode_r[feed_ch_r] ? ca_r[feed_ch_r] : ma_r[feed_ch_r];
    assign wr_ok = (awaddr_r == `TPO_A_CTRL) || (awaddr_r == `TPO_A_FIFO)
                 || (awaddr_r == `TPO_A_DEVCMD) || (awaddr_r == `TPO_A_TAKEOVER)
                 || (awaddr_r[7:5] == `TPO_CH_REGION);
    // Write completes when both halves in and target has room
    assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid
                 && !(awaddr_r == `TPO_A_FIFO && !fifo_in_ready)
                 && !(awaddr_r == `TPO_A_DEVCMD && dev_pend_r);

    // Timer channels; B may clear for period plus margin
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : chn
            logic [15:0] cnt_r;
            logic hit_a;
            logic hit_b;
            assign hit_a = run_r[c] && !cap_mode_r[c] && cnt_r == cmp_a_r[c];
            assign hit_b = run_r[c] && cnt_r == cmp_b_r[c];
            always_ff @(posedge aclk) begin
                if (!aresetn || !run_r[c]) begin
                    cnt_r <= '0;
                end else if (clr_b_r[c] ? hit_b : hit_a) begin
                    cnt_r <= '0;
                end else begin
                    cnt_r <= cnt_r + 16'h1;
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ma_r[c] <= 1'b0;
                    mb_r[c] <= 1'b0;
                    ca_r[c] <= 1'b0;
                    cap_prev_r[c] <= 1'b0;
                end else begin
                    ma_r[c] <= hit_a;
                    mb_r[c] <= hit_b;
                    cap_prev_r[c] <= capture_in[c];
                    ca_r[c] <= run_r[c] && cap_mode_r[c] && capture_in[c] && !cap_prev_r[c];
                end
            end
        end
    endgenerate

    // Controller register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_r <= '0;
            feed_en_r <= 1'b0;
            feed_ch_r <= '0;
            take_r <= '0;
            cap_mode_r <= '0;
            clr_b_r <= '0;
            for (int i = 0; i < 4; i++) begin
                cmp_a_r[i] <= '0;
                cmp_b_r[i] <= '0;
            end
        end else if (do_wr) begin
            if (awaddr_r == `TPO_A_CTRL) begin
                run_r <= wdata_r[3:0];
                feed_en_r <= wdata_r[4];
                feed_ch_r <= wdata_r[6:5];
            end
            // Pin function changes only while timers stop
            if (awaddr_r == `TPO_A_TAKEOVER && run_r == '0) begin
                take_r <= wdata_r[15:0];
            end
            if (awaddr_r[7:5] == `TPO_CH_REGION && !awaddr_r[2]) begin
                cmp_a_r[awaddr_r[4:3]] <= wdata_r[15:0];
                cap_mode_r[awaddr_r[4:3]] <= wdata_r[`TPO_CH_MODE_BIT];
            end
            if (awaddr_r[7:5] == `TPO_CH_REGION && awaddr_r[2]) begin
                cmp_b_r[awaddr_r[4:3]] <= wdata_r[15:0];
                clr_b_r[awaddr_r[4:3]] <= wdata_r[`TPO_CH_MODE_BIT];
            end
        end
    end

    tpo_fifo #(.WIDTH(16), .DEPTH(`TPO_FIFO_DEPTH)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(do_wr && awaddr_r == `TPO_A_FIFO),
        .in_ready(fifo_in_ready),
        .in_data(wdata_r[15:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out),
        .count(fifo_cnt)
    );

    // Feeder: preload, then reload after each match A, or after each capture when the channel captures
    assign fifo_pop = (feed_r == FEED_HI);
    always_ff @(posedge aclk) begin
        if (!aresetn || !feed_en_r) begin
            feed_r <= FEED_IDLE;
        end else begin
            case (feed_r)
                FEED_IDLE: feed_r <= FEED_LO;
                FEED_WAIT: if (trig_a) feed_r <= FEED_LO;
                FEED_LO: if (fifo_out_valid) feed_r <= FEED_HI;
                FEED_HI: feed_r <= FEED_WAIT;
                default: feed_r <= FEED_IDLE;
            endcase
        end
    end

    // Device port drive; feeder before commands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rwr_r <= 1'b0;
            rrd_r <= 1'b0;
            ridx_r <= '0;
            rwdata_r <= '0;
            dev_pend_r <= 1'b0;
            dev_is_rd_r <= 1'b0;
            dev_idx_r <= '0;
            dev_data_r <= '0;
            dev_rd_r <= '0;
            dev_rd_wait_r <= 1'b0;
        end else begin
            rwr_r <= 1'b0;
            rrd_r <= 1'b0;
            dev_rd_wait_r <= rrd_r;
            if (dev_rd_wait_r) begin
                dev_rd_r <= link.reg_rdata;
            end
            if (do_wr && awaddr_r == `TPO_A_DEVCMD) begin
                dev_pend_r <= 1'b1;
                dev_is_rd_r <= wdata_r[`TPO_CMD_RD_BIT];
                dev_idx_r <= wdata_r[19:16];
                dev_data_r <= wdata_r[7:0];
            end
            if (feed_r == FEED_LO && fifo_out_valid) begin
                rwr_r <= 1'b1;
                ridx_r <= `TPO_IDX_NPAT_LO;
                rwdata_r <= fifo_out[7:0];
            end else if (feed_r == FEED_HI) begin
                rwr_r <= 1'b1;
                ridx_r <= `TPO_IDX_NPAT_HI;
                rwdata_r <= fifo_out[15:8];
            end else if (dev_pend_r && !feed_busy) begin
                dev_pend_r <= 1'b0;
                rwr_r <= !dev_is_rd_r;
                rrd_r <= dev_is_rd_r;
                ridx_r <= dev_idx_r;
                rwdata_r <= dev_data_r;
            end
        end
    end

    assign link.reg_wr = rwr_r;
    assign link.reg_rd = rrd_r;
    assign link.reg_idx = ridx_r;
    assign link.reg_wdata = rwdata_r;
    assign link.match_a = ma_r;
    assign link.match_b = mb_r;
    assign link.capture_a = ca_r;
    assign link.capture_mode = cap_mode_r;
    assign link.takeover = take_r;

    // AXI write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TPO_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `TPO_RESP_OKAY : `TPO_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `TPO_A_CTRL: rd_mux = {25'h0, feed_ch_r, feed_en_r, run_r};
            `TPO_A_STATUS: rd_mux = {20'h0, dev_pend_r, feed_r, fifo_in_ready,
                                     fifo_out_valid, 2'h0, fifo_cnt[4:0]};
            `TPO_A_DEVRD: rd_mux = {24'h0, dev_rd_r};
            `TPO_A_TAKEOVER: rd_mux = {16'h0, take_r};
            default: begin
                rd_mux = '0;
                rd_ok = 1'b0;
                if (s_axi_araddr[7:5] == `TPO_CH_REGION) begin
                    rd_ok = 1'b1;
                    rd_mux = s_axi_araddr[2]
                        ? {15'h0, clr_b_r[s_axi_araddr[4:3]], cmp_b_r[s_axi_araddr[4:3]]}
                        : {15'h0, cap_mode_r[s_axi_araddr[4:3]], cmp_a_r[s_axi_araddr[4:3]]};
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `TPO_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `TPO_RESP_OKAY : `TPO_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

//--- dv/tpo_properties.sv
// Checker for the pattern output link and pins
`timescale 1ns/100ps
module tpo_properties (
    // Clock, reset, strobes
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_idx,
    input wire logic [7:0] reg_wdata,
    // Timer events and pins
    input wire logic [3:0] match_a,
    input wire logic [3:0] match_b,
    input wire logic [3:0] capture_a,
    input wire logic [3:0] capture_mode,
    input wire logic [15:0] takeover,
    input wire logic [15:0] pattern_pin_out,
    input wire logic [15:0] pattern_pin_oe,
    input wire logic [15:0] pattern_active
);
    logic [15:0] np_r, ne_r, dr_r, fm, zm, om, cz, pm, act, lk;
    logic [7:0] ts_r;
    logic [3:0] nv_r;
    logic [1:0] c;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Device register shadow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {np_r, ne_r, dr_r} <= 48'h0;
            ts_r <= 8'hff;
            nv_r <= 4'h0;
        end else if (reg_wr) begin
            case (reg_idx)
                4'h0: np_r[7:0] <= reg_wdata;
                4'h1: np_r[15:8] <= reg_wdata;
                4'h2: ne_r[7:0] <= reg_wdata;
                4'h3: ne_r[15:8] <= reg_wdata;
                4'h4: dr_r[7:0] <= reg_wdata;
                4'h5: dr_r[15:8] <= reg_wdata;
                4'h8: ts_r <= reg_wdata;
                4'h9: nv_r <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end
    // Expected masks per group
    always_comb begin
        {fm, zm, om} = 48'h0;
        for (int g = 0; g < 4; g++) begin
            c = ts_r[2*g +: 2];
            if (capture_mode[c] ? capture_a[c] : match_a[c]) begin
                fm[4*g +: 4] = ne_r[4*g +: 4];
            end else if (nv_r[g] && match_b[c] && !capture_mode[c]) begin
                zm[4*g +: 4] = ne_r[4*g +: 4] & ~np_r[4*g +: 4];
                om[4*g +: 4] = ne_r[4*g +: 4] & np_r[4*g +: 4];
            end
        end
        cz = fm | zm;
        pm = np_r & fm;
        act = dr_r & ne_r & ~takeover;
        lk = ne_r & ~dr_r;
    end
    a_full_copy: assert property (|fm |=> (pattern_pin_out & $past(fm)) == $past(pm))
        else $error("next bits not copied");
    a_zero_first: assert property (|zm |=> (pattern_pin_out & $past(zm)) == 16'h0)
        else $error("zeros late at b");
    a_ones_wait: assert property (|om && !reg_wr |=>
        ((pattern_pin_out ^ $past(pattern_pin_out)) & $past(om)) == 16'h0)
        else $error("ones moved at b");
    a_idle_hold: assert property (!reg_wr |=>
        ((pattern_pin_out ^ $past(pattern_pin_out)) & ~$past(cz)) == 16'h0)
        else $error("pins moved untriggered");
    a_input_lock: assert property (reg_wr && reg_idx[3:1] == 3'h3 && cz == 16'h0 |=>
        ((pattern_pin_out ^ $past(pattern_pin_out)) & $past(lk)) == 16'h0)
        else $error("locked port bit written");
    a_active_mask: assert property (1'b1 |=> pattern_active == $past(act))
        else $error("active mask wrong");
    a_oe_cover: assert property ((pattern_active & ~pattern_pin_oe) == 16'h0)
        else $error("active pin not driven");
    a_strobe_excl: assert property (!(reg_wr && reg_rd))
        else $error("read and write together");
    cover property (|zm);
    cover property (|(capture_a & capture_mode));
    cover property (|(match_a & match_b));
endmodule

//--- dv/tb.sv
// Bench joining controller and device through the link
`timescale 1ns/100ps
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp;
    logic [3:0] capture_in;
    logic [15:0] pin_in, pattern_pin_out, pattern_pin_oe, pattern_active;
    int mismatches, num_checks;
    tpo_if lk (.aclk(aclk), .aresetn(aresetn));
    tpo_ctrl i_tpo_ctrl (.link(lk), .capture_in(capture_in), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    tpo_device i_tpo_device (.link(lk), .pin_in(pin_in), .pattern_pin_out(pattern_pin_out),
        .pattern_pin_oe(pattern_pin_oe), .pattern_active(pattern_active));
    tpo_properties i_tpo_properties (.aclk(aclk), .aresetn(aresetn), .reg_wr(lk.reg_wr),
        .reg_rd(lk.reg_rd), .reg_idx(lk.reg_idx), .reg_wdata(lk.reg_wdata),
        .match_a(lk.match_a), .match_b(lk.match_b), .capture_a(lk.capture_a),
        .capture_mode(lk.capture_mode), .takeover(lk.takeover),
        .pattern_pin_out(pattern_pin_out), .pattern_pin_oe(pattern_pin_oe),
        .pattern_active(pattern_active));
    task automatic test_done;
        if (mismatches == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic ck(input logic [31:0] g, x);
        num_checks++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
        int n = 0;
        {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'h3};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && ++n < 3000);
        if (!bvalid) begin
            mismatches++;
            test_done;
        end
        ck({30'h0, bresp}, {30'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] e = 2'h0);
        int n = 0;
        {araddr, arvalid} <= {a, 1'b1};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && ++n < 3000);
        if (!rvalid) begin
            mismatches++;
            test_done;
        end
        d = rdata;
        ck({30'h0, rresp}, {30'h0, e});
    endtask
    task automatic dw(input logic [3:0] i, input logic [7:0] v);
        wr(8'h0c, {12'h0, i, 8'h0, v});
    endtask
    task automatic dr(input logic [3:0] i, input logic [7:0] x);
        wr(8'h0c, {11'h1, i, 16'h0});
        repeat (3) @(posedge aclk);
        rd(8'h10);
        ck(d & 32'hff, {24'h0, x});
    endtask
    task automatic wp(input logic [15:0] m, input logic [15:0] v);
        for (int n = 0; (pattern_pin_out & m) !== v && n < 3000; n++) @(posedge aclk);
        ck({16'h0, pattern_pin_out & m}, {16'h0, v});
    endtask
    task automatic t_reset;
        dr(4'h8, 8'hff);
        dr(4'h9, 8'hf0);
        wr(8'h40, 32'h1, 2'h2);
        rd(8'h40, 2'h2);
        ck(d, 32'h0);
    endtask
    task automatic t_norm;
        dw(4'h5, 8'hff);
        dw(4'h7, 8'h3c);
        dw(4'h3, 8'hff);
        dw(4'h8, 8'he4);
        dw(4'h1, 8'ha5);
        wp(16'hff00, 16'h3c00);
        ck({16'h0, pattern_active}, 32'hff00);
        wr(8'h30, 32'h1e);
        wr(8'h38, 32'h1e);
        wr(8'h00, 32'h4);
        wp(16'hff00, 16'h3500);
        wr(8'h00, 32'hc);
        wp(16'hff00, 16'ha500);
        wr(8'h00, 32'h0);
    endtask
    task automatic t_feed;
        for (int k = 0; k < 32; k++) wr(8'h08, {16'h0, k[7:0], ~k[7:0]});
        rd(8'h04);
        ck(d & 32'h1ff, 32'h80);
        dw(4'h4, 8'hff);
        dw(4'h2, 8'hff);
        dw(4'h8, 8'h00);
        wr(8'h20, 32'h28);
        wr(8'h00, 32'h11);
        for (int k = 0; k < 32; k++) wp(16'hffff, {k[7:0], ~k[7:0]});
        rd(8'h04);
        ck(d & 32'h19f, 32'h100);
        wr(8'h00, 32'h0);
    endtask
    task automatic t_nov;
        dw(4'h8, 8'h55);
        dw(4'h9, 8'h0f);
        dw(4'h0, 8'h6a);
        dw(4'h1, 8'h6a);
        wr(8'h28, 32'h14);
        wr(8'h2c, 32'h10032);
        wr(8'h00, 32'h2);
        wp(16'hffff, 16'h6a6a);
        wr(8'h28, 32'h32);
        dw(4'h0, 8'h95);
        dw(4'h1, 8'h95);
        wp(16'hffff, 16'h9595);
        wr(8'h00, 32'h0);
        dw(4'h9, 8'h00);
    endtask
    task automatic t_cap;
        dw(4'h8, 8'haa);
        wr(8'h30, 32'h10000);
        dw(4'h0, 8'h34);
        dw(4'h1, 8'h12);
        wr(8'h00, 32'h4);
        capture_in <= 4'h4;
        wp(16'hffff, 16'h1234);
        capture_in <= 4'h0;
        dw(4'h5, 8'h00);
        dw(4'h7, 8'h00);
        repeat (2) @(posedge aclk);
        ck({16'h0, pattern_pin_out}, 32'h1234);
        wr(8'h00, 32'h0);
        wr(8'h14, 32'hff);
        dw(4'h0, 8'h77);
        dw(4'h1, 8'h77);
        wr(8'h00, 32'h4);
        capture_in <= 4'h4;
        wp(16'hffff, 16'h7777);
        ck({16'h0, pattern_pin_oe}, 32'h0);
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h05;
        {awaddr, araddr, wdata, d} = 80'h0;
        capture_in = 4'h0;
        pin_in = 16'ha5a5;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_norm;
        t_feed;
        t_nov;
        t_cap;
        test_done;
    end
endmodule
